//--- sbrc_pkg.sv
// sbrc_pkg: constants, register map and state types of the standby and reset control
`default_nettype none
package sbrc_pkg;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 4;
    localparam int PC_W       = 13;
    localparam int IRQ_N      = 8;
    localparam int IRQ_IDX_Z  = 2;
    // program-memory words read after reset
    localparam logic [PC_W-1:0] PM_ADDR_HI = 13'h0000;
    localparam logic [PC_W-1:0] PM_ADDR_LO = 13'h0001;
    localparam int PCH_SMALL_W = 4;
    localparam int PCH_LARGE_W = 5;
    localparam int BANK_BIT    = 7;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_PC_LO  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_PC_HI  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_SKIP   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_BANK   = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_TMODE  = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_WMODE  = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_TCNT   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TMOD   = 4'h9;
    // control fields
    localparam int CTRL_W        = 4;
    localparam int CTRL_SIO_EXT  = 0;
    localparam int CTRL_TMR_EXT  = 1;
    localparam int CTRL_WCH_SUB  = 2;
    localparam int CTRL_MAIN_OFF = 3;
    // status fields above the state code
    localparam int STAT_RETAIN = 5;
    localparam int STAT_REFUSE = 6;
    localparam int STAT_BANK   = 7;
    localparam int SKIP_W      = 3;
    localparam int IST_BIT     = 3;
    localparam int BSEL_W      = 4;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [DATA_W-1:0] ZERO_RST = 8'h00;
    localparam logic [DATA_W-1:0] TMOD_RST = 8'hFF;
    typedef enum logic [4:0] {
        SBRC_FETCH_HI = 5'h01,
        SBRC_FETCH_LO = 5'h02,
        SBRC_LOAD     = 5'h04,
        SBRC_RUN      = 5'h08,
        SBRC_HALT     = 5'h10
    } sbrc_mode_t;
    typedef struct packed {
        sbrc_mode_t        mode;
        logic              stop;
        logic [CTRL_W-1:0] ctrl;
        logic              retain;
        logic              refused;
        logic              bank_en;
        logic [PC_W-1:0]   pc;
        logic              pc_load;
        logic              pm_rd;
        logic [PC_W-1:0]   pm_addr;
        logic [DATA_W-1:0] word_hi;
        logic [SKIP_W-1:0] skip;
        logic              ist;
        logic [BSEL_W-1:0] bsel;
        logic [DATA_W-1:0] tmode;
        logic [DATA_W-1:0] wmode;
        logic [DATA_W-1:0] tcnt;
        logic [DATA_W-1:0] tmod;
        logic [DATA_W-1:0] rdata;
        logic              main_osc;
        logic              sub_osc;
        logic              cpu_clk;
        logic              bit_run;
        logic              sio_run;
        logic              tmr_run;
        logic              wch_run;
        logic              adc_run;
        logic [3:0]        xint;
    } sbrc_state_t;
endpackage
`default_nettype wire

//--- sbrc_top.sv
// sbrc_top: standby state machine, peripheral gating and reset-vector load
//
// Contract
// - stop accepted only on main system clock
// - halt accepted on either clock
// - stop halts main oscillator only
// - halt gates only the processor clock
// - interval timer stopped; halt needs main oscillator
// - serial in stop only with external clock
// - serial in halt: external clock or main
// - counter in stop only with pin source
// - counter in halt: pin source or main
// - watch in stop needs subclock; halt always
// - converter off in stop; halt needs main
// - interrupts one, two, four live; zero dead
// - enabled interrupt request or reset ends standby
// - reset puts all hardware in known state
// - small part: pc 11:8 and 7:0 loaded
// - large part: pc 12:8 and 7:0 loaded
// - bank enable from bit seven, word zero
// - reset during run loads same as standby
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sbrc_top
    import sbrc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              stop_instr,
    input  wire logic              halt_instr,
    input  wire logic              cpu_on_subclock,
    input  wire logic [IRQ_N-1:0]  irq_req,
    input  wire logic [IRQ_N-1:0]  irq_enable,
    output logic                   pm_rd,
    output logic      [PC_W-1:0]   pm_addr,
    input  wire logic [DATA_W-1:0] pm_data,
    output logic                   pc_load,
    output logic      [PC_W-1:0]   pc_value,
    output logic                   bank_enable_flag,
    output logic                   retain_state,
    output logic      [SKIP_W-1:0] skip_flags,
    output logic                   irq_status_flag,
    output logic      [BSEL_W-1:0] bank_select_reg,
    output logic      [DATA_W-1:0] timer_mode_reg,
    output logic      [DATA_W-1:0] watch_mode_reg,
    output logic      [DATA_W-1:0] timer_count_reg,
    output logic      [DATA_W-1:0] timer_modulo_reg,
    output logic                   main_osc_en,
    output logic                   sub_osc_en,
    output logic                   cpu_clk_en,
    output logic                   interval_timer_run,
    output logic                   serial_run,
    output logic                   timer_run,
    output logic                   watch_run,
    output logic                   adc_run,
    output logic                   ext_irq_zero_en,
    output logic                   ext_irq_one_en,
    output logic                   ext_irq_two_en,
    output logic                   ext_irq_four_en
);

    generate
        if (DATA_W != 8 || PC_W < PCH_LARGE_W + DATA_W) begin : g_bad
            $error("sbrc_top: word widths not supported");
        end
        if (IRQ_IDX_Z >= IRQ_N) begin : g_bad_irq
            $error("sbrc_top: interrupt index out of range");
        end
    endgenerate

    // a peripheral with a pin-driven clock runs in any standby;
    // otherwise it needs the main oscillator
    function automatic logic pin_or_main(
        input logic ext_sel,
        input logic main_on
    );
        pin_or_main = ext_sel || main_on;
    endfunction

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        hit = (a == ofs);
    endfunction

    sbrc_state_t st_reg;
    sbrc_state_t st_next;

    logic [IRQ_N-1:0] wake_mask;
    logic             wake;
    logic             standby;
    logic [PC_W-1:0]  pc_new;

    always_comb begin
        st_next   = st_reg;
        wake_mask = '1;
        // zero input is dead while the core sleeps
        wake_mask[IRQ_IDX_Z] = 1'b0;
        wake      = |(irq_req & irq_enable & wake_mask);
        standby   = (st_reg.mode == SBRC_HALT);
        pc_new    = '0;
        st_next.pc_load = 1'b0;
        st_next.pm_rd   = 1'b0;
        st_next.rdata   = ZERO_RST;

        unique case (st_reg.mode)
            SBRC_FETCH_HI: begin
                // first word arrives next cycle; ask for the second
                st_next.pm_rd   = 1'b1;
                st_next.pm_addr = PM_ADDR_LO;
                st_next.mode    = SBRC_FETCH_LO;
            end
            SBRC_FETCH_LO: begin
                st_next.word_hi = pm_data;
                st_next.mode    = SBRC_LOAD;
            end
            SBRC_LOAD: begin
                pc_new[DATA_W-1:0] = pm_data;
                if (LARGE_VARIANT) begin
                    pc_new[DATA_W +: PCH_LARGE_W] =
                        st_reg.word_hi[PCH_LARGE_W-1:0];
                end else begin
                    pc_new[DATA_W +: PCH_SMALL_W] =
                        st_reg.word_hi[PCH_SMALL_W-1:0];
                end
                st_next.pc      = pc_new;
                st_next.bank_en = st_reg.word_hi[BANK_BIT];
                st_next.pc_load = 1'b1;
                st_next.mode    = SBRC_RUN;
            end
            SBRC_RUN: begin
                if (stop_instr && !cpu_on_subclock) begin
                    st_next.mode = SBRC_HALT;
                    st_next.stop = 1'b1;
                end else if (halt_instr) begin
                    st_next.mode = SBRC_HALT;
                    st_next.stop = 1'b0;
                end
            end
            SBRC_HALT: begin
                if (wake) begin
                    st_next.mode = SBRC_RUN;
                    st_next.stop = 1'b0;
                end
            end
        endcase

        // sticky refusal of a stop issued on the subclock;
        // a refusal in the clearing cycle survives the clear
        if (reg_wr && hit(reg_addr, OFS_STATUS) && reg_wdata[STAT_REFUSE]) begin
            st_next.refused = 1'b0;
        end
        if (st_reg.mode == SBRC_RUN && stop_instr && cpu_on_subclock) begin
            st_next.refused = 1'b1;
        end

        if (reg_wr) begin
            if (hit(reg_addr, OFS_CTRL)) begin
                st_next.ctrl = reg_wdata[CTRL_W-1:0];
            end
            if (hit(reg_addr, OFS_SKIP)) begin
                st_next.skip = reg_wdata[SKIP_W-1:0];
                st_next.ist  = reg_wdata[IST_BIT];
            end
            if (hit(reg_addr, OFS_BANK)) begin
                st_next.bsel = reg_wdata[BSEL_W-1:0];
            end
            if (hit(reg_addr, OFS_TMODE)) begin
                st_next.tmode = reg_wdata;
            end
            if (hit(reg_addr, OFS_WMODE)) begin
                st_next.wmode = reg_wdata;
            end
            if (hit(reg_addr, OFS_TCNT)) begin
                st_next.tcnt = reg_wdata;
            end
            if (hit(reg_addr, OFS_TMOD)) begin
                st_next.tmod = reg_wdata;
            end
        end

        if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, OFS_CTRL): begin
                    st_next.rdata = DATA_W'(st_reg.ctrl);
                end
                hit(reg_addr, OFS_STATUS): begin
                    st_next.rdata = {st_reg.bank_en, st_reg.refused,
                                     st_reg.retain, st_reg.mode};
                    st_next.rdata[CTRL_W] = st_reg.stop ? 1'b1 : st_reg.mode[4];
                end
                hit(reg_addr, OFS_PC_LO): begin
                    st_next.rdata = st_reg.pc[DATA_W-1:0];
                end
                hit(reg_addr, OFS_PC_HI): begin
                    st_next.rdata = DATA_W'(st_reg.pc[PC_W-1:DATA_W]);
                end
                hit(reg_addr, OFS_SKIP): begin
                    st_next.rdata = DATA_W'({st_reg.ist, st_reg.skip});
                end
                hit(reg_addr, OFS_BANK): begin
                    st_next.rdata = DATA_W'(st_reg.bsel);
                end
                hit(reg_addr, OFS_TMODE): begin
                    st_next.rdata = st_reg.tmode;
                end
                hit(reg_addr, OFS_WMODE): begin
                    st_next.rdata = st_reg.wmode;
                end
                hit(reg_addr, OFS_TCNT): begin
                    st_next.rdata = st_reg.tcnt;
                end
                hit(reg_addr, OFS_TMOD): begin
                    st_next.rdata = st_reg.tmod;
                end
                default: begin
                    // unmapped offsets read as zero
                    st_next.rdata = ZERO_RST;
                end
            endcase
        end

        // gates follow the next mode so each enable flips with the mode
        begin : gating
            logic nx_sleep;
            logic nx_stop;
            logic nx_main;
            nx_sleep = (st_next.mode == SBRC_HALT);
            nx_stop  = nx_sleep && st_next.stop;
            nx_main  = !nx_stop && !st_next.ctrl[CTRL_MAIN_OFF];
            // a main clock parked by software stays parked in halt
            st_next.main_osc = nx_main;
            st_next.sub_osc  = 1'b1;
            st_next.cpu_clk  = (st_next.mode == SBRC_RUN);
            st_next.bit_run  = nx_main;
            st_next.sio_run  = nx_stop ? st_next.ctrl[CTRL_SIO_EXT]
                             : pin_or_main(st_next.ctrl[CTRL_SIO_EXT], nx_main);
            st_next.tmr_run  = nx_stop ? st_next.ctrl[CTRL_TMR_EXT]
                             : pin_or_main(st_next.ctrl[CTRL_TMR_EXT], nx_main);
            st_next.wch_run  = nx_stop ? st_next.ctrl[CTRL_WCH_SUB] : 1'b1;
            st_next.adc_run  = nx_main;
            st_next.xint     = {3'h7, !nx_sleep};
        end

        if (reset) begin
            // every control field to a known value before execution resumes
            st_next         = '0;
            st_next.mode    = SBRC_FETCH_HI;
            st_next.pm_rd   = 1'b1;
            st_next.pm_addr = PM_ADDR_HI;
            st_next.ctrl    = CTRL_RST;
            st_next.skip    = '0;
            st_next.ist     = 1'b0;
            st_next.bsel    = '0;
            st_next.tmode   = ZERO_RST;
            st_next.wmode   = ZERO_RST;
            st_next.tcnt    = ZERO_RST;
            st_next.tmod    = TMOD_RST;
            st_next.sub_osc = 1'b1;
            st_next.main_osc = 1'b1;
            // held across a reset that stays asserted;
            // an unknown power-up state falls through to cleared
            if (standby || (st_reg.retain && st_reg.mode == SBRC_FETCH_HI)) begin
                st_next.retain = 1'b1;
            end
            st_next.xint    = 4'hF;
        end
    end

    always_ff @(posedge core_clk) begin
        st_reg <= st_next;
    end

    assign reg_rdata          = st_reg.rdata;
    assign pm_rd              = st_reg.pm_rd;
    assign pm_addr            = st_reg.pm_addr;
    assign pc_load            = st_reg.pc_load;
    assign pc_value           = st_reg.pc;
    assign bank_enable_flag   = st_reg.bank_en;
    assign retain_state       = st_reg.retain;
    assign skip_flags         = st_reg.skip;
    assign irq_status_flag    = st_reg.ist;
    assign bank_select_reg    = st_reg.bsel;
    assign timer_mode_reg     = st_reg.tmode;
    assign watch_mode_reg     = st_reg.wmode;
    assign timer_count_reg    = st_reg.tcnt;
    assign timer_modulo_reg   = st_reg.tmod;
    assign main_osc_en        = st_reg.main_osc;
    assign sub_osc_en         = st_reg.sub_osc;
    assign cpu_clk_en         = st_reg.cpu_clk;
    assign interval_timer_run = st_reg.bit_run;
    assign serial_run         = st_reg.sio_run;
    assign timer_run          = st_reg.tmr_run;
    assign watch_run          = st_reg.wch_run;
    assign adc_run            = st_reg.adc_run;
    assign ext_irq_zero_en    = st_reg.xint[0];
    assign ext_irq_one_en     = st_reg.xint[1];
    assign ext_irq_two_en     = st_reg.xint[2];
    assign ext_irq_four_en    = st_reg.xint[3];

endmodule // sbrc_top
`default_nettype wire

//--- sbrc_checker.sv
// sbrc_checker: port assertions for standby entry, gating, wake and reset load
`timescale 1ns/100ps
`default_nettype none
module sbrc_checker
    import sbrc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic              core_clk,
    input wire logic              reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              stop_instr,
    input wire logic              halt_instr,
    input wire logic              cpu_on_subclock,
    input wire logic [IRQ_N-1:0]  irq_req,
    input wire logic [IRQ_N-1:0]  irq_enable,
    input wire logic              pm_rd,
    input wire logic [PC_W-1:0]   pm_addr,
    input wire logic [DATA_W-1:0] pm_data,
    input wire logic              pc_load,
    input wire logic [PC_W-1:0]   pc_value,
    input wire logic              bank_enable_flag,
    input wire logic [SKIP_W-1:0] skip_flags,
    input wire logic              irq_status_flag,
    input wire logic [BSEL_W-1:0] bank_select_reg,
    input wire logic [DATA_W-1:0] timer_mode_reg,
    input wire logic [DATA_W-1:0] watch_mode_reg,
    input wire logic [DATA_W-1:0] timer_count_reg,
    input wire logic [DATA_W-1:0] timer_modulo_reg,
    input wire logic              main_osc_en,
    input wire logic              sub_osc_en,
    input wire logic              cpu_clk_en,
    input wire logic              interval_timer_run,
    input wire logic              serial_run,
    input wire logic              timer_run,
    input wire logic              watch_run,
    input wire logic              adc_run,
    input wire logic              ext_irq_zero_en,
    input wire logic              ext_irq_one_en,
    input wire logic              ext_irq_two_en,
    input wire logic              ext_irq_four_en
);
    logic [CTRL_W-1:0] ctrl_reg;
    logic              sb_reg, stp_reg, rd_q_reg, enter, enter_stop, wake;
    logic [PC_W-1:0]   addr_q_reg, exp_pc;
    logic [DATA_W-1:0] w0_reg, w1_reg;
    // cpu clock high means the run state, so it qualifies entry
    assign enter_stop = cpu_clk_en && stop_instr && !cpu_on_subclock;
    assign enter = enter_stop || (cpu_clk_en && halt_instr);
    assign wake = |(irq_req & irq_enable & ~(IRQ_N'(1) << IRQ_IDX_Z));
    assign exp_pc = LARGE_VARIANT ? {w0_reg[PCH_LARGE_W-1:0], w1_reg} : {1'b0, w0_reg[PCH_SMALL_W-1:0], w1_reg};
    always_ff @(posedge core_clk) begin
        rd_q_reg <= pm_rd;
        addr_q_reg <= pm_addr;
        if (rd_q_reg && addr_q_reg == PM_ADDR_HI)
            w0_reg <= pm_data;
        if (rd_q_reg && addr_q_reg == PM_ADDR_LO)
            w1_reg <= pm_data;
        if (reset) begin
            ctrl_reg <= CTRL_RST;
            sb_reg <= 1'b0;
            stp_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFS_CTRL)
                ctrl_reg <= reg_wdata[CTRL_W-1:0];
            if (sb_reg && wake)
                sb_reg <= 1'b0;
            else if (enter) begin
                sb_reg <= 1'b1;
                stp_reg <= enter_stop;
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_stop_entry: assert property (enter_stop |=> !cpu_clk_en && !main_osc_en && sub_osc_en)
        else $error("stop entry gating wrong");
    a_halt_entry: assert property (cpu_clk_en && halt_instr && !stop_instr |=> !cpu_clk_en && sub_osc_en)
        else $error("halt entry gating wrong");
    a_stop_refused: assert property (cpu_clk_en && stop_instr && cpu_on_subclock && !halt_instr |=> cpu_clk_en)
        else $error("stop on subclock accepted");
    a_stop_gates: assert property (sb_reg && stp_reg |-> !main_osc_en && !interval_timer_run && !adc_run
        && serial_run == ctrl_reg[CTRL_SIO_EXT] && timer_run == ctrl_reg[CTRL_TMR_EXT] && watch_run == ctrl_reg[CTRL_WCH_SUB])
        else $error("stop peripheral gating wrong");
    a_halt_gates: assert property (sb_reg && !stp_reg |-> main_osc_en != ctrl_reg[CTRL_MAIN_OFF]
        && interval_timer_run == main_osc_en && adc_run == main_osc_en && watch_run
        && serial_run == (ctrl_reg[CTRL_SIO_EXT] || main_osc_en) && timer_run == (ctrl_reg[CTRL_TMR_EXT] || main_osc_en))
        else $error("halt peripheral gating wrong");
    a_irq_zero_dead: assert property (sb_reg |-> !ext_irq_zero_en && ext_irq_one_en && ext_irq_two_en && ext_irq_four_en)
        else $error("standby interrupt inputs wrong");
    a_wake_exit: assert property (sb_reg && wake |=> cpu_clk_en)
        else $error("enabled request did not wake");
    a_no_false_wake: assert property (sb_reg && !wake |=> !cpu_clk_en)
        else $error("standby left without enabled request");
    a_reset_fetch: assert property ($fell(reset) |-> pm_rd && pm_addr == PM_ADDR_HI ##1 pm_rd && pm_addr == PM_ADDR_LO
        ##1 !pm_rd ##1 pc_load && cpu_clk_en)
        else $error("reset fetch sequence wrong");
    a_pc_vector: assert property (pc_load |-> pc_value == exp_pc && bank_enable_flag == w0_reg[BANK_BIT])
        else $error("reset vector or bank flag wrong");
    a_reset_clears: assert property ($fell(reset) |-> skip_flags == '0 && !irq_status_flag
        && bank_select_reg == '0 && timer_mode_reg == ZERO_RST && watch_mode_reg == ZERO_RST
        && timer_count_reg == ZERO_RST && timer_modulo_reg == TMOD_RST)
        else $error("reset register values wrong");
    c_halt_wake: cover property (sb_reg && !stp_reg && wake);
    c_stop_wake: cover property (sb_reg && stp_reg && wake);
    c_refused: cover property (cpu_clk_en && stop_instr && cpu_on_subclock);
endmodule // sbrc_checker
`default_nettype wire

//--- sbrc_pmem_model.sv
// sbrc_pmem_model: program memory answering the reset-vector fetches
`timescale 1ns/100ps
`default_nettype none
module sbrc_pmem_model
    import sbrc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              pm_rd,
    input  wire logic [PC_W-1:0]   pm_addr,
    input  wire logic [DATA_W-1:0] word_hi,
    input  wire logic [DATA_W-1:0] word_lo,
    output logic      [DATA_W-1:0] pm_data
);
    // without a read the word flips, so stale data never passes as valid
    always_ff @(posedge core_clk) begin
        if (!pm_rd)
            pm_data <= ~pm_data;
        else if (pm_addr == PM_ADDR_HI)
            pm_data <= word_hi;
        else if (pm_addr == PM_ADDR_LO)
            pm_data <= word_lo;
        else
            pm_data <= ~pm_addr[DATA_W-1:0];
    end
endmodule // sbrc_pmem_model
`default_nettype wire

//--- sbrc_tb.sv
// sbrc_tb: register-level tests of standby and reset control
`timescale 1ns/100ps
`default_nettype none
module sbrc_tb
    import sbrc_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset, reg_wr, reg_rd, stop_instr, halt_instr, cpu_on_subclock, pm_rd, retain_state, cpu_clk_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, pm_data, word_hi, word_lo;
    logic [IRQ_N-1:0]  irq_req, irq_enable;
    logic [PC_W-1:0]   pm_addr;
    int                error_cnt, num_checks;
    logic [ADDR_W-1:0] zero_ofs [6] = '{OFS_CTRL, OFS_SKIP, OFS_BANK, OFS_TMODE, OFS_WMODE, OFS_TCNT};
    logic [CTRL_W-1:0] cset [5] = '{4'h0, 4'hB, 4'h4, 4'h7, 4'h8};
    int                wset [5] = '{1, 4, 6, 0, 7};
    always #2 core_clk = ~core_clk;
    sbrc_top #(.LARGE_VARIANT(1'b1)) sbrc_top_i (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_instr(stop_instr), .halt_instr(halt_instr),
        .cpu_on_subclock(cpu_on_subclock), .irq_req(irq_req), .irq_enable(irq_enable), .pm_rd(pm_rd),
        .pm_addr(pm_addr), .pm_data(pm_data), .pc_load(), .pc_value(), .bank_enable_flag(),
        .retain_state(retain_state), .skip_flags(), .irq_status_flag(), .bank_select_reg(), .timer_mode_reg(),
        .watch_mode_reg(), .timer_count_reg(), .timer_modulo_reg(), .main_osc_en(), .sub_osc_en(),
        .cpu_clk_en(cpu_clk_en), .interval_timer_run(), .serial_run(), .timer_run(), .watch_run(), .adc_run(),
        .ext_irq_zero_en(), .ext_irq_one_en(), .ext_irq_two_en(), .ext_irq_four_en());
    sbrc_pmem_model sbrc_pmem_model_i (.core_clk(core_clk), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .word_hi(word_hi), .word_lo(word_lo), .pm_data(pm_data));
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    // data stand one cycle only, so they are looked at mid-cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask
    task automatic reset_load(input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1, input logic ret);
        word_hi <= w0;
        word_lo <= w1;
        reset <= 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk({7'h00, retain_state}, {7'h00, ret});
        @(posedge core_clk);
        rd(OFS_STATUS, {w0[BANK_BIT], 1'b0, ret, 5'h08});
        rd(OFS_PC_HI, {3'h0, w0[PCH_LARGE_W-1:0]});
        rd(OFS_PC_LO, w1);
    endtask
    // interrupt zero and a disabled source are held pending first: neither may wake
    task automatic standby(input logic is_stop, input logic [CTRL_W-1:0] c, input int wb);
        wr(OFS_CTRL, {4'h0, c});
        irq_req <= 8'h04 | (8'h01 << wb);
        irq_enable <= 8'h04;
        stop_instr <= is_stop;
        halt_instr <= !is_stop;
        @(posedge core_clk);
        stop_instr <= 1'b0;
        halt_instr <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(OFS_STATUS, {word_hi[BANK_BIT], 7'h10});
        irq_enable <= 8'hFF;
        repeat (2) @(posedge core_clk);
        irq_req <= 8'h00;
        @(negedge core_clk);
        chk({7'h00, cpu_clk_en}, 8'h01);
        @(posedge core_clk);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        stop_instr = 1'b0;
        halt_instr = 1'b0;
        cpu_on_subclock = 1'b0;
        irq_req = 8'h00;
        irq_enable = 8'hFF;
        word_hi = 8'h00;
        word_lo = 8'h00;
        error_cnt = 0;
        num_checks = 0;
        @(posedge core_clk);
        reset_load(8'h9B, 8'h3C, 1'b0);
        foreach (zero_ofs[i])
            rd(zero_ofs[i], ZERO_RST);
        rd(OFS_TMOD, TMOD_RST);
        rd(4'hF, 8'h00);
        for (int i = 0; i < 5; i++) begin
            cpu_on_subclock <= (i == 2);
            standby(i > 2, cset[i], wset[i]);
        end
        cpu_on_subclock <= 1'b1;
        stop_instr <= 1'b1;
        @(posedge core_clk);
        stop_instr <= 1'b0;
        @(posedge core_clk);
        rd(OFS_STATUS, {word_hi[BANK_BIT], 7'h48});
        wr(OFS_STATUS, 8'h40);
        rd(OFS_STATUS, {word_hi[BANK_BIT], 7'h08});
        cpu_on_subclock <= 1'b0;
        halt_instr <= 1'b1;
        @(posedge core_clk);
        halt_instr <= 1'b0;
        @(posedge core_clk);
        reset_load(8'h45, 8'hA7, 1'b1);
        reset_load(8'hFF, 8'h00, 1'b0);
        end_of_test();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        error_cnt++;
        $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
        end_of_test();
    end
endmodule // sbrc_tb
bind sbrc_top sbrc_checker #(.LARGE_VARIANT(LARGE_VARIANT)) sbrc_checker_i (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .stop_instr(stop_instr), .halt_instr(halt_instr), .cpu_on_subclock(cpu_on_subclock), .irq_req(irq_req),
    .irq_enable(irq_enable), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data), .pc_load(pc_load),
    .pc_value(pc_value), .bank_enable_flag(bank_enable_flag), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
    .skip_flags(skip_flags), .irq_status_flag(irq_status_flag), .bank_select_reg(bank_select_reg),
    .timer_mode_reg(timer_mode_reg), .watch_mode_reg(watch_mode_reg), .timer_count_reg(timer_count_reg),
    .timer_modulo_reg(timer_modulo_reg),
    .cpu_clk_en(cpu_clk_en), .interval_timer_run(interval_timer_run), .serial_run(serial_run),
    .timer_run(timer_run), .watch_run(watch_run), .adc_run(adc_run), .ext_irq_zero_en(ext_irq_zero_en),
    .ext_irq_one_en(ext_irq_one_en), .ext_irq_two_en(ext_irq_two_en), .ext_irq_four_en(ext_irq_four_en));
`default_nettype wire
